/* File: src/stl_spi_target.sv */
// Contract
// - Device is a serial target only; it never drives clock or select.
// - Mode 0: capture on rising clock edge, change data on falling edge.
// - Select is active low; device addressed only while it is low.
// - Addresses, commands, messages and data arrive on the serial data input.
// - Serial data output is three-state so targets share the return line.
// - Load-enable low: normal mode, own logic handles serial traffic.
// - Load-enable high: serial bus routed straight to the nonvolatile memory.
// - Device stays in reset while the reset input is low.
// - After reset release device boots about 1 to 3 s, then adapts.
// - Message buffer read or write frame lasts exactly 56 clock cycles.
// - Status or checksum frame lasts exactly 32 clock cycles.
module stl_spi_target
    import stl_pkg::*;
#(
    parameter int unsigned BOOT_CYCLES = BOOT_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic target_select_n,
    input wire logic serial_data_input,
    output logic serial_data_output,
    output logic serial_data_output_en_n,
    input wire logic firmware_load_enable,
    input wire logic device_reset_n,
    output logic nvm_sclk,
    output logic nvm_select_n,
    output logic nvm_data_in,
    input wire logic nvm_data_out,
    output logic core_reset,
    output logic adapt_enable,
    output logic [31:0] host_message,
    output logic [7:0] host_checksum,
    output logic message_strobe,
    output logic checksum_strobe,
    input wire logic [31:0] core_reply,
    input wire logic [7:0] core_status,
    input wire logic [7:0] core_checksum,
    input wire logic core_reply_load
);
    function automatic logic [7:0] rsp_byte(input logic [7:0] op, input logic [1:0] idx,
                                            input logic [31:0] word, input logic [7:0] st,
                                            input logic [7:0] chk);
        case (op)
            OP_RSR_READ: rsp_byte = st;
            OP_CHK_READ: rsp_byte = chk;
            OP_MRB_READ: rsp_byte = word[8*(3-idx) +: 8];
            default: rsp_byte = 8'h00;
        endcase
    endfunction

    // Reply registers live on mclk; they load core values only while select is high,
    // so the serial side reads them as static values during a frame.
    logic [31:0] reply_word;
    logic [7:0] status_byte;
    logic [7:0] reply_chk;

    // ---------------- Serial clock domain ----------------
    logic [5:0] bit_cnt;
    logic [6:0] rx_shift;
    logic [7:0] opcode;
    logic mrb_done;
    logic chk_done;
    logic [31:0] msg_word;
    logic [7:0] chk_rx;
    logic tx_bit;
    logic tx_en;
    logic [5:0] next_bit_cnt;
    logic [6:0] next_rx_shift;
    logic [7:0] next_opcode;
    logic next_mrb_done;
    logic next_chk_done;
    logic [31:0] next_msg_word;
    logic [7:0] next_chk_rx;
    logic next_tx_bit;
    logic next_tx_en;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [5:0] frame_len;
    logic [5:0] rel_cnt;
    logic in_data;
    logic byte_end;
    logic frame_end;

    always_comb begin
        frame_len = stl_frame_len(opcode);
        rel_cnt = bit_cnt - OPCODE_BITS;
        in_data = (bit_cnt >= OPCODE_BITS) && (bit_cnt < frame_len);
        rx_byte = {rx_shift, serial_data_input};
        byte_end = in_data && (bit_cnt[2:0] == BYTE_LAST);
        frame_end = (frame_len != NO_FRAME) && (bit_cnt == frame_len - 6'h01);
        next_bit_cnt = (bit_cnt == BIT_CNT_MAX) ? bit_cnt : bit_cnt + 6'h01;
        next_rx_shift = rx_byte[6:0];
        next_opcode = (bit_cnt == OPCODE_LAST) ? rx_byte : opcode;
        next_msg_word = msg_word;
        next_chk_rx = chk_rx;
        if (byte_end && (opcode == OP_MRB_WRITE)) begin
            next_msg_word = {msg_word[23:0], rx_byte};
        end
        if (byte_end && (opcode == OP_CHK_WRITE)) begin
            next_chk_rx = rx_byte;
        end
        next_mrb_done = mrb_done | (frame_end && (opcode == OP_MRB_WRITE));
        next_chk_done = chk_done | (frame_end && (opcode == OP_CHK_WRITE));
        next_tx_en = in_data && stl_is_read(opcode);
        tx_byte = rsp_byte(opcode, rel_cnt[4:3], reply_word, status_byte, reply_chk);
        next_tx_bit = next_tx_en && tx_byte[~bit_cnt[2:0]];
    end

    // Deselect clears frame state at once and holds it cleared
    always_ff @(posedge spi_sclk or posedge target_select_n) begin
        if (target_select_n) begin
            bit_cnt <= 6'h00;
            rx_shift <= 7'h00;
            opcode <= 8'h00;
            mrb_done <= 1'b0;
            chk_done <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            opcode <= next_opcode;
            mrb_done <= next_mrb_done;
            chk_done <= next_chk_done;
        end
    end

    // Received data are held past the frame for mclk to collect
    always_ff @(posedge spi_sclk) begin
        msg_word <= next_msg_word;
        chk_rx <= next_chk_rx;
    end

    // Outgoing bit changes on the falling edge
    always_ff @(negedge spi_sclk or posedge target_select_n) begin
        if (target_select_n) begin
            tx_bit <= 1'b0;
            tx_en <= 1'b0;
        end else begin
            tx_bit <= next_tx_bit;
            tx_en <= next_tx_en;
        end
    end

    // ---------------- System clock domain ----------------
    logic [5:0] pin_s;
    logic [3:0] ev_s;
    logic sclk_s;
    logic ssn_s;
    logic sdi_s;
    logic load_s;
    logic rstn_s;
    logic nvm_s;
    logic mrb_done_s;
    logic chk_done_s;
    logic tx_bit_s;
    logic tx_en_s;

    stl_sync #(.WIDTH(6), .IDLE(PIN_IDLE)) u_pin_sync (
        .clk(mclk),
        .rst(sys_rst),
        .d({nvm_data_out, device_reset_n, firmware_load_enable, serial_data_input,
            target_select_n, spi_sclk}),
        .q(pin_s)
    );

    stl_sync #(.WIDTH(4), .IDLE(4'h0)) u_link_sync (
        .clk(mclk),
        .rst(sys_rst),
        .d({tx_en, tx_bit, chk_done, mrb_done}),
        .q(ev_s)
    );

    assign {nvm_s, rstn_s, load_s, sdi_s, ssn_s, sclk_s} = pin_s;
    assign {tx_en_s, tx_bit_s, chk_done_s, mrb_done_s} = ev_s;

    stl_boot_e boot;
    stl_boot_e next_boot;
    logic [BOOT_CNT_W-1:0] boot_cnt;
    logic [BOOT_CNT_W-1:0] next_boot_cnt;
    logic mrb_prev;
    logic chk_prev;
    logic accept;
    logic next_serial_data_output;
    logic next_serial_data_output_en_n;
    logic next_nvm_sclk;
    logic next_nvm_select_n;
    logic next_nvm_data_in;
    logic next_message_strobe;
    logic next_checksum_strobe;
    logic [31:0] next_host_message;
    logic [7:0] next_host_checksum;
    logic [31:0] next_reply_word;
    logic [7:0] next_status_byte;
    logic [7:0] next_reply_chk;

    always_comb begin
        next_boot = boot;
        next_boot_cnt = boot_cnt;
        case (boot)
            BOOT_HELD: begin
                next_boot_cnt = '0;
                if (rstn_s && !load_s) begin
                    next_boot = BOOT_RUN;
                end
            end
            BOOT_RUN: begin
                if (boot_cnt == BOOT_CNT_W'(BOOT_CYCLES - 1)) begin
                    next_boot = BOOT_DONE;
                end else begin
                    next_boot_cnt = boot_cnt + 1'b1;
                end
            end
            BOOT_DONE: next_boot = BOOT_DONE;
            default: next_boot = BOOT_HELD;
        endcase
        if (!rstn_s) begin
            next_boot = BOOT_HELD;
        end

        accept = !load_s && (boot == BOOT_DONE);
        next_message_strobe = accept && mrb_done_s && !mrb_prev;
        next_checksum_strobe = accept && chk_done_s && !chk_prev;
        next_host_message = next_message_strobe ? msg_word : host_message;
        next_host_checksum = next_checksum_strobe ? chk_rx : host_checksum;

        next_reply_word = reply_word;
        next_status_byte = status_byte;
        next_reply_chk = reply_chk;
        if (!rstn_s) begin
            next_reply_word = REPLY_RESET;
            next_status_byte = STATUS_RESET;
            next_reply_chk = CHECKSUM_RESET;
        end else if (core_reply_load && ssn_s) begin
            next_reply_word = core_reply;
            next_status_byte = core_status;
            next_reply_chk = core_checksum;
        end

        if (load_s) begin
            next_nvm_sclk = sclk_s;
            next_nvm_select_n = ssn_s;
            next_nvm_data_in = sdi_s;
            next_serial_data_output = nvm_s;
            next_serial_data_output_en_n = ssn_s;
        end else begin
            next_nvm_sclk = 1'b0;
            next_nvm_select_n = 1'b1;
            next_nvm_data_in = 1'b0;
            next_serial_data_output = tx_bit_s;
            next_serial_data_output_en_n = !(accept && !ssn_s && tx_en_s);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            boot <= BOOT_HELD;
            boot_cnt <= '0;
            mrb_prev <= 1'b0;
            chk_prev <= 1'b0;
            core_reset <= 1'b1;
            adapt_enable <= 1'b0;
            message_strobe <= 1'b0;
            checksum_strobe <= 1'b0;
            host_message <= 32'h00000000;
            host_checksum <= 8'h00;
            reply_word <= REPLY_RESET;
            status_byte <= STATUS_RESET;
            reply_chk <= CHECKSUM_RESET;
            nvm_sclk <= 1'b0;
            nvm_select_n <= 1'b1;
            nvm_data_in <= 1'b0;
            serial_data_output <= 1'b0;
            serial_data_output_en_n <= 1'b1;
        end else begin
            boot <= next_boot;
            boot_cnt <= next_boot_cnt;
            mrb_prev <= mrb_done_s;
            chk_prev <= chk_done_s;
            core_reset <= !rstn_s;
            adapt_enable <= (next_boot == BOOT_DONE);
            message_strobe <= next_message_strobe;
            checksum_strobe <= next_checksum_strobe;
            host_message <= next_host_message;
            host_checksum <= next_host_checksum;
            reply_word <= next_reply_word;
            status_byte <= next_status_byte;
            reply_chk <= next_reply_chk;
            nvm_sclk <= next_nvm_sclk;
            nvm_select_n <= next_nvm_select_n;
            nvm_data_in <= next_nvm_data_in;
            serial_data_output <= next_serial_data_output;
            serial_data_output_en_n <= next_serial_data_output_en_n;
        end
    end
    // clock and select are inputs only; nothing here drives them back.
endmodule // stl_spi_target

/* File: src/stl_pkg.sv */
package stl_pkg;
    // System clock and boot timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int BOOT_TIME_S = 1;
    localparam int BOOT_CYCLES_DEF = BOOT_TIME_S * CLK_FREQ_HZ;
    localparam int BOOT_CNT_W = 27;

    // Serial frame layout, counted in serial clock cycles
    localparam int BIT_CNT_W = 6;
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [5:0] OPCODE_BITS = 6'h18;
    localparam logic [5:0] MRB_FRAME_BITS = 6'h38;
    localparam logic [5:0] SHORT_FRAME_BITS = 6'h20;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3F;
    localparam logic [5:0] NO_FRAME = 6'h00;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    // First opcode byte selects the transaction
    localparam logic [7:0] OP_MRB_READ = 8'hE0;
    localparam logic [7:0] OP_MRB_WRITE = 8'hF0;
    localparam logic [7:0] OP_RSR_READ = 8'hC8;
    localparam logic [7:0] OP_CHK_READ = 8'hD5;
    localparam logic [7:0] OP_CHK_WRITE = 8'hD4;

    // Reply contents after reset
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CHECKSUM_RESET = 8'h00;
    localparam logic [31:0] REPLY_RESET = 32'h00000000;

    // Input synchroniser idle levels: data out, reset, load, data in, select, clock
    localparam logic [5:0] PIN_IDLE = 6'h22;

    typedef enum logic [1:0] {
        BOOT_HELD = 2'b00,
        BOOT_RUN = 2'b01,
        BOOT_DONE = 2'b11
    } stl_boot_e;

    function automatic logic [5:0] stl_frame_len(input logic [7:0] op);
        case (op)
            OP_MRB_READ, OP_MRB_WRITE: stl_frame_len = MRB_FRAME_BITS;
            OP_RSR_READ, OP_CHK_READ, OP_CHK_WRITE: stl_frame_len = SHORT_FRAME_BITS;
            default: stl_frame_len = NO_FRAME;
        endcase
    endfunction

    function automatic logic stl_is_read(input logic [7:0] op);
        stl_is_read = (op == OP_MRB_READ) || (op == OP_RSR_READ) || (op == OP_CHK_READ);
    endfunction
endpackage

/* File: src/stl_sync.sv */
module stl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= IDLE;
            q <= IDLE;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // stl_sync

/* File: verification/stl_spi_target_checker.sv */
module stl_spi_target_checker
    import stl_pkg::*;
#(
    parameter int unsigned BOOT_CYCLES = BOOT_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic target_select_n,
    input wire logic serial_data_input,
    input wire logic serial_data_output,
    input wire logic serial_data_output_en_n,
    input wire logic firmware_load_enable,
    input wire logic device_reset_n,
    input wire logic nvm_sclk,
    input wire logic nvm_select_n,
    input wire logic nvm_data_in,
    input wire logic nvm_data_out,
    input wire logic core_reset,
    input wire logic adapt_enable,
    input wire logic message_strobe,
    input wire logic checksum_strobe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Cycles since the core left reset, to judge the boot length
    logic [31:0] boot_cnt;
    logic [31:0] next_boot_cnt;
    always_comb begin
        next_boot_cnt = boot_cnt + 32'h1;
        if (sys_rst || core_reset) begin
            next_boot_cnt = 32'h0;
        end
    end
    always_ff @(posedge mclk) begin
        boot_cnt <= next_boot_cnt;
    end

    chk_unselected_release: assert property (
        (target_select_n && !firmware_load_enable)[*5] |-> serial_data_output_en_n)
        else $error("data out driven while not selected");
    chk_reset_holds: assert property (!device_reset_n[*4] |-> core_reset)
        else $error("core left reset while reset pin low");
    chk_reset_no_adapt: assert property (core_reset[*2] |-> !adapt_enable)
        else $error("adapting while in reset");
    chk_boot_length: assert property ($rose(adapt_enable) |->
        boot_cnt + 32'h3 >= BOOT_CYCLES && boot_cnt <= BOOT_CYCLES + 32'h3)
        else $error("boot length wrong");
    chk_strobe_gated: assert property (
        (message_strobe || checksum_strobe) |-> adapt_enable && !firmware_load_enable)
        else $error("strobe outside normal mode");
    chk_load_route: assert property ((firmware_load_enable && !sys_rst)[*6] |->
        nvm_sclk == $past(spi_sclk, 3) && nvm_data_in == $past(serial_data_input, 3)
        && nvm_select_n == $past(target_select_n, 3))
        else $error("pins not routed to memory");
    chk_load_return: assert property ((firmware_load_enable && !sys_rst)[*6] |->
        serial_data_output_en_n == $past(target_select_n, 3)
        && (serial_data_output_en_n || serial_data_output == $past(nvm_data_out, 3)))
        else $error("memory data not returned");
    chk_memory_idle: assert property (
        !firmware_load_enable[*5] |-> nvm_select_n && !nvm_sclk)
        else $error("memory touched in normal mode");

    cover property (message_strobe);
    cover property (checksum_strobe);
    cover property ($rose(adapt_enable));
    cover property (firmware_load_enable && !nvm_select_n);
endmodule // stl_spi_target_checker

bind stl_spi_target stl_spi_target_checker #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (
    .mclk, .sys_rst, .spi_sclk, .target_select_n, .serial_data_input,
    .serial_data_output, .serial_data_output_en_n, .firmware_load_enable,
    .device_reset_n, .nvm_sclk, .nvm_select_n, .nvm_data_in, .nvm_data_out,
    .core_reset, .adapt_enable, .message_strobe, .checksum_strobe);

/* File: verification/stl_host_model.sv */
module stl_host_model (
    output logic sclk,
    output logic sel_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Top of the allowed clock range, even duty
    localparam time HALF = 125;

    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end

    // Sends the top n bits of tx, MSB first; received bits shift into rx
    task automatic xfer(input int n, input logic [55:0] tx, output logic [55:0] rx);
        rx = '0;
        sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = tx[55-i];
            #HALF;
            sclk = 1'b1;
            rx = {rx[54:0], miso};
            #HALF;
            sclk = 1'b0;
        end
        // Released input falls to its pull-down
        mosi = 1'b0;
        #HALF;
        sel_n = 1'b1;
        #HALF;
    endtask
endmodule // stl_host_model

/* File: verification/spi_target_with_load_and_reset_tb_top.sv */
module spi_target_with_load_and_reset_tb_top
    import stl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BOOT = 50;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sclk, target_select_n, serial_data_input, miso;
    logic serial_data_output, serial_data_output_en_n, nvm_sclk, nvm_select_n, nvm_data_in;
    logic firmware_load_enable = 1'b0;
    logic device_reset_n = 1'b0;
    logic nvm_data_out = 1'b0;
    logic core_reset, adapt_enable, message_strobe, checksum_strobe;
    logic [31:0] host_message;
    logic [7:0] host_checksum;
    logic [31:0] core_reply = 32'h0;
    logic [7:0] core_status = 8'h0;
    logic [7:0] core_checksum = 8'h0;
    logic core_reply_load = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int n_msg = 0;
    int n_chk = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;
    // Data out is open to an external pull-up when released
    assign miso = serial_data_output_en_n ? 1'b1 : serial_data_output;

    stl_spi_target #(.BOOT_CYCLES(BOOT)) DUT (.mclk, .sys_rst, .spi_sclk, .target_select_n,
        .serial_data_input, .serial_data_output, .serial_data_output_en_n,
        .firmware_load_enable, .device_reset_n, .nvm_sclk, .nvm_select_n, .nvm_data_in,
        .nvm_data_out, .core_reset, .adapt_enable, .host_message, .host_checksum,
        .message_strobe, .checksum_strobe, .core_reply, .core_status, .core_checksum,
        .core_reply_load);
    stl_host_model host (.sclk(spi_sclk), .sel_n(target_select_n),
        .mosi(serial_data_input), .miso(miso));

    // Memory stand-in echoes its input one cycle later
    always @(posedge mclk) nvm_data_out <= nvm_data_in;

    always @(posedge mclk) begin
        cycles++;
        if (message_strobe === 1'b1) n_msg++;
        if (checksum_strobe === 1'b1) n_chk++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] want, input logic [31:0] got);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", name, want, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_boot;
        // Reset pin held low over 1 us before release
        tick(100);
        check("core_reset", 32'h1, core_reset);
        device_reset_n = 1'b1;
        tick(BOOT - 8);
        check("adapt_early", 32'h0, adapt_enable);
        // Messaging waits for the scaled boot to end
        tick(16);
        check("adapt_done", 32'h1, adapt_enable);
    endtask

    task automatic t_write;
        logic [55:0] rx;
        host.xfer(40, {OP_MRB_WRITE, 16'h0020, 32'h1111_1111}, rx);
        tick(10);
        check("short_frame_strobes", 32'h0, n_msg);
        host.xfer(56, {OP_MRB_WRITE, 16'h0020, 32'h5A3C_96E1}, rx);
        tick(10);
        check("write_strobes", 32'h1, n_msg);
        check("host_message", 32'h5A3C_96E1, host_message);
    endtask

    task automatic t_reads;
        logic [55:0] rx;
        logic [7:0] ops [3] = '{OP_RSR_READ, OP_CHK_READ, 8'h3C};
        logic [7:0] want [3] = '{8'h0F, 8'hB4, 8'hFF};
        tick(1);
        core_reply = 32'hC3A5_1E78;
        core_status = 8'h0F;
        core_checksum = 8'hB4;
        core_reply_load = 1'b1;
        tick(1);
        core_reply_load = 1'b0;
        for (int i = 0; i < 3; i++) begin
            host.xfer(32, {ops[i], 16'h0028, 8'h69, 24'h0}, rx);
            check("short_reply", {24'h0, want[i]}, {24'h0, rx[7:0]});
        end
        host.xfer(32, {OP_CHK_WRITE, 16'h0028, 8'h69, 24'h0}, rx);
        tick(10);
        check("checksum_write", 32'h69, host_checksum);
        check("checksum_strobes", 32'h1, n_chk);
        host.xfer(56, {OP_MRB_READ, 48'h0}, rx);
        check("reply_word", 32'hC3A5_1E78, rx[31:0]);
    endtask

    task automatic t_load;
        logic [55:0] rx;
        device_reset_n = 1'b0;
        tick(4);
        firmware_load_enable = 1'b1;
        tick(8);
        host.xfer(8, {8'hA5, 48'h0}, rx);
        check("memory_echo", 32'hA5, {24'h0, rx[7:0]});
        host.xfer(56, {OP_MRB_WRITE, 16'h0020, 32'h0F0F_0F0F}, rx);
        tick(10);
        check("load_strobes", 32'h1, n_msg);
        check("load_message", 32'h5A3C_96E1, host_message);
        firmware_load_enable = 1'b0;
        tick(8);
        check("memory_idle", 32'h1, nvm_select_n);
        device_reset_n = 1'b1;
        tick(BOOT + 10);
        check("reboot", 32'h1, adapt_enable);
    endtask

    initial begin
        tick(16);
        sys_rst = 1'b0;
        t_boot();
        t_write();
        t_reads();
        t_load();
        tally_and_finish();
    end
endmodule // spi_target_with_load_and_reset_tb_top
